// ---- core/ehr_map.svh ----
`ifndef EHR_MAP_SVH
`define EHR_MAP_SVH
// ==========================================================
// command codes of the register bank
`define EHR_CMD_SNAPSHOT   8'hdc
`define EHR_CMD_THR_LOW    8'hf2
`define EHR_CMD_THR_HIGH   8'hf3
`define EHR_CMD_STATUS     8'hf4
`define EHR_CMD_STARTUP    8'hf6
// ==========================================================
// reset values
`define EHR_RST_THR_LOW    16'h0000
`define EHR_RST_THR_HIGH   16'hffff
`define EHR_RST_STARTUP    4'hf
// ==========================================================
// status bit positions
`define EHR_ST_BELOW       0
`define EHR_ST_ABOVE       1
`define EHR_ST_LEVEL       2
`define EHR_ST_OVERCUR     3
// ==========================================================
// snapshot field positions
`define EHR_SNAP_COUNT_LSB 40
`define EHR_SNAP_WRAP_LSB  24
// ==========================================================
// gpo mode code that routes the comparator out
`define EHR_GPO_COMPARATOR 2'h3
`endif

// ---- core/ehr_pkg.sv ----
// ==========================================================
// types shared by the register bank
package ehr_pkg;
  // one energy snapshot, packed in wire order
  typedef struct packed {
    logic [23:0] sampleCount;       // bytes 7..5
    logic [15:0] energyWrapCount;   // bytes 4..3
    logic [23:0] energyAccumValue;  // bytes 2..0
  } ehr_snapshot_t;

  // register access request from the management interface
  typedef struct packed {
    logic        wrEn;              // one-cycle write strobe
    logic        rdEn;              // one-cycle read strobe
    logic [7:0]  cmd;               // command code
    logic [15:0] wrData;            // write data
  } ehr_req_t;

  // comparator states
  typedef enum logic [0:0] {
    EHR_LOW  = 1'b0,
    EHR_HIGH = 1'b1
  } ehr_level_t;
endpackage : ehr_pkg

// ---- core/energy_and_hysteresis_regs.sv ----
`timescale 1ns/1ns
`include "ehr_map.svh"
module energy_and_hysteresis_regs
  import ehr_pkg::*;
(
  input  wire logic          clock,              // 125 MHz core clock
  input  wire logic          sys_rst,            // synchronous, active high
  input  wire ehr_req_t      req,                // register access request
  input  wire logic          sampleValid,        // one power sample accumulated
  input  wire logic          accumWrap,          // accumulator wrapped to zero
  input  wire logic [23:0]   energyAccumIn,      // live accumulator value
  input  wire logic [15:0]   comparedValue,      // value fed to the comparator
  input  wire logic          overcurrentPin,     // monitor overcurrent compare, async
  input  wire logic [1:0]    gpoMode,            // output pin mode select
  input  wire logic          gpoManual,          // pin level in plain gpo mode
  output logic [63:0]        rdData,             // read data, low bits for short regs
  output logic               rdValid,            // read data valid pulse
  output logic               gpoOut,             // general output pin level
  output logic [3:0]         startupCurrentCap   // limit used during switch turn-on
);

  // ==========================================================
  // live counters
  logic [23:0] sampleCount;        // samples accumulated
  logic [15:0] energyWrapCount;    // accumulator wraps
  logic [15:0] thrLow;             // band_threshold_low
  logic [15:0] thrHigh;            // band_threshold_high
  logic [2:0]  ocSync;             // overcurrent synchroniser
  logic        outputOvercurrentFlag; // filtered overcurrent level
  ehr_level_t  bandLevel;          // comparator state
  logic        aboveUpperFlag;     // compared value above high
  logic        belowLowerFlag;     // compared value below low
  ehr_snapshot_t snap;             // coherent snapshot
  logic [7:0]  statusByte;         // band_status image

  // counts increase per sample and per wrap
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sampleCount     <= 24'h000000;
      energyWrapCount <= 16'h0000;
    end
    else
    begin
      if (sampleValid)
        sampleCount <= sampleCount + 24'h000001;
      if (accumWrap)
        energyWrapCount <= energyWrapCount + 16'h0001;
    end
  end

  // ==========================================================
  // threshold and startup registers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      thrLow            <= `EHR_RST_THR_LOW;
      thrHigh           <= `EHR_RST_THR_HIGH;
      startupCurrentCap <= `EHR_RST_STARTUP;
    end
    else if (req.wrEn)
    begin
      // writes to read-only or unknown codes are ignored
      case (req.cmd)
        `EHR_CMD_THR_LOW:  thrLow  <= req.wrData;
        `EHR_CMD_THR_HIGH: thrHigh <= req.wrData;
        `EHR_CMD_STARTUP:  startupCurrentCap <= req.wrData[3:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // overcurrent input synchroniser, change taken when stages 2 and 3 agree
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ocSync                <= 3'h0;
      outputOvercurrentFlag <= 1'b0;
    end
    else
    begin
      ocSync <= {ocSync[1:0], overcurrentPin};
      if (ocSync[1] == ocSync[2])
        outputOvercurrentFlag <= ocSync[2];
    end
  end

  // ==========================================================
  // hysteretic comparator
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      bandLevel      <= EHR_LOW;
      aboveUpperFlag <= 1'b0;
      belowLowerFlag <= 1'b0;
    end
    else
    begin
      aboveUpperFlag <= (comparedValue > thrHigh);
      belowLowerFlag <= (comparedValue < thrLow);
      unique case (bandLevel)
        EHR_LOW:
          if (comparedValue > thrHigh)
            bandLevel <= EHR_HIGH;
        EHR_HIGH:
          if (comparedValue < thrLow)
            bandLevel <= EHR_LOW;
      endcase
    end
  end

  // status image, upper nibble held at zero
  always_comb
  begin
    statusByte = 8'h00;
    statusByte[`EHR_ST_OVERCUR] = outputOvercurrentFlag;
    statusByte[`EHR_ST_LEVEL]   = (bandLevel == EHR_HIGH);
    statusByte[`EHR_ST_ABOVE]   = aboveUpperFlag;
    statusByte[`EHR_ST_BELOW]   = belowLowerFlag;
  end

  // ==========================================================
  // output pin mux
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      gpoOut <= 1'b0;
    else if (gpoMode == `EHR_GPO_COMPARATOR)
      gpoOut <= (bandLevel == EHR_HIGH);
    else
      gpoOut <= gpoManual;
  end

  // ==========================================================
  // read path, snapshot captured in one cycle
  always_comb
  begin
    snap.sampleCount      = sampleCount;
    snap.energyWrapCount  = energyWrapCount;
    snap.energyAccumValue = energyAccumIn;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdData  <= 64'h0;
      rdValid <= 1'b0;
    end
    else
    begin
      rdValid <= req.rdEn;
      if (req.rdEn)
      begin
        case (req.cmd)
          `EHR_CMD_SNAPSHOT: rdData <= snap;
          `EHR_CMD_THR_LOW:  rdData <= {48'h0, thrLow};
          `EHR_CMD_THR_HIGH: rdData <= {48'h0, thrHigh};
          `EHR_CMD_STATUS:   rdData <= {56'h0, statusByte};
          `EHR_CMD_STARTUP:  rdData <= {60'h0, startupCurrentCap};
          default:           rdData <= 64'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  a_snap_count: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_SNAPSHOT |=> rdData[63:40] == $past(sampleCount))
    else $error("snapshot sample count wrong");
  a_snap_wrap: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_SNAPSHOT |=> rdData[39:24] == $past(energyWrapCount))
    else $error("snapshot wrap count wrong");
  a_snap_energy: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_SNAPSHOT |=> rdData[23:0] == $past(energyAccumIn))
    else $error("snapshot energy wrong");
  a_read_valid: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn |=> rdValid)
    else $error("read answer missing");
  a_count_step: assert property (@(posedge clock) disable iff (sys_rst)
    sampleValid |=> sampleCount == $past(sampleCount) + 24'h000001)
    else $error("sample count did not step");
  a_band_rise: assert property (@(posedge clock) disable iff (sys_rst)
    comparedValue > thrHigh |=> bandLevel == EHR_HIGH)
    else $error("level did not rise");
  a_band_fall: assert property (@(posedge clock) disable iff (sys_rst)
    comparedValue < thrLow && !(comparedValue > thrHigh) |=> bandLevel == EHR_LOW)
    else $error("level did not fall");
  a_status_zero: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_STATUS |=> rdData[63:4] == 60'h0)
    else $error("status reserved bits set");
  a_cap_read: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_STARTUP |=> rdData[63:0] == {60'h0, $past(startupCurrentCap)})
    else $error("startup read wrong");
  a_gpo_band: assert property (@(posedge clock) disable iff (sys_rst)
    gpoMode == `EHR_GPO_COMPARATOR |=> gpoOut == ($past(bandLevel) == EHR_HIGH))
    else $error("gpo not following comparator");

  // ==========================================================
  // read answer checks
  // the answer pulse stands one cycle, then drops
  a_read_idle: assert property (@(posedge clock) disable iff (sys_rst)
    !req.rdEn |=> !rdValid)
    else $error("read answer without request");
  // the whole snapshot comes from the request edge
  a_snap_whole: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_SNAPSHOT |=> rdData == $past(snap))
    else $error("snapshot not coherent");
  // threshold reads sit in the low half word
  a_low_read: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_THR_LOW |=> rdData == {48'h0, $past(thrLow)})
    else $error("low threshold read wrong");
  a_high_read: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_THR_HIGH |=> rdData == {48'h0, $past(thrHigh)})
    else $error("high threshold read wrong");
  // reserved startup bits answer as zero
  a_cap_reserved: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_STARTUP |=> rdData[15:4] == 12'h000)
    else $error("startup reserved bits set");
  // each status bit mirrors its source at the request edge
  a_status_warn: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_STATUS |=> rdData[3] == $past(outputOvercurrentFlag))
    else $error("status warning bit wrong");
  a_status_level: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_STATUS |=> rdData[2] == ($past(bandLevel) == EHR_HIGH))
    else $error("status level bit wrong");
  a_status_above: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_STATUS |=> rdData[1] == $past(aboveUpperFlag))
    else $error("status above bit wrong");
  a_status_below: assert property (@(posedge clock) disable iff (sys_rst)
    req.rdEn && req.cmd == `EHR_CMD_STATUS |=> rdData[0] == $past(belowLowerFlag))
    else $error("status below bit wrong");

  // ==========================================================
  // register write checks
  // a write lands one cycle after its strobe
  a_low_write: assert property (@(posedge clock) disable iff (sys_rst)
    req.wrEn && req.cmd == `EHR_CMD_THR_LOW |=> thrLow == $past(req.wrData))
    else $error("low threshold write lost");
  a_high_write: assert property (@(posedge clock) disable iff (sys_rst)
    req.wrEn && req.cmd == `EHR_CMD_THR_HIGH |=> thrHigh == $past(req.wrData))
    else $error("high threshold write lost");
  // only the low nibble of a startup write is kept
  a_cap_write: assert property (@(posedge clock) disable iff (sys_rst)
    req.wrEn && req.cmd == `EHR_CMD_STARTUP |=>
      {12'h000, startupCurrentCap} == ($past(req.wrData) & 16'h000f))
    else $error("startup write lost");
  // registers keep their value unless written at their own code
  a_low_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(req.wrEn && req.cmd == `EHR_CMD_THR_LOW) |=> $stable(thrLow))
    else $error("low threshold changed unasked");
  a_high_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(req.wrEn && req.cmd == `EHR_CMD_THR_HIGH) |=> $stable(thrHigh))
    else $error("high threshold changed unasked");
  a_cap_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(req.wrEn && req.cmd == `EHR_CMD_STARTUP) |=> $stable(startupCurrentCap))
    else $error("startup cap changed unasked");

  // ==========================================================
  // counter checks
  // wraps step by one, idle cycles leave both counts alone
  a_wrap_step: assert property (@(posedge clock) disable iff (sys_rst)
    accumWrap |=> energyWrapCount == $past(energyWrapCount) + 16'h0001)
    else $error("wrap count did not step");
  a_count_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !sampleValid |=> $stable(sampleCount))
    else $error("sample count moved unasked");
  a_wrap_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !accumWrap |=> $stable(energyWrapCount))
    else $error("wrap count moved unasked");

  // ==========================================================
  // comparator and flag checks
  // between the thresholds the level is held
  a_band_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(comparedValue > thrHigh) && !(comparedValue < thrLow) |=> $stable(bandLevel))
    else $error("level moved inside band");
  // the raw flags follow the strict compares one cycle later
  a_above_set: assert property (@(posedge clock) disable iff (sys_rst)
    comparedValue > thrHigh |=> aboveUpperFlag)
    else $error("above flag not set");
  a_above_clear: assert property (@(posedge clock) disable iff (sys_rst)
    !(comparedValue > thrHigh) |=> !aboveUpperFlag)
    else $error("above flag not clear");
  a_below_set: assert property (@(posedge clock) disable iff (sys_rst)
    comparedValue < thrLow |=> belowLowerFlag)
    else $error("below flag not set");
  a_below_clear: assert property (@(posedge clock) disable iff (sys_rst)
    !(comparedValue < thrLow) |=> !belowLowerFlag)
    else $error("below flag not clear");
  // the warning may only move once two stages agree
  a_warn_filter: assert property (@(posedge clock) disable iff (sys_rst)
    ocSync[1] != ocSync[2] |=> $stable(outputOvercurrentFlag))
    else $error("warning moved on a glitch");
  // outside comparator mode the pin copies the manual level
  a_gpo_manual: assert property (@(posedge clock) disable iff (sys_rst)
    gpoMode != `EHR_GPO_COMPARATOR |=> gpoOut == $past(gpoManual))
    else $error("gpo not following manual level");

  // ==========================================================
  // reset value checks
  // these run while reset is high, so they carry no disable
  a_rst_low: assert property (@(posedge clock)
    sys_rst |=> thrLow == `EHR_RST_THR_LOW)
    else $error("low threshold reset wrong");
  a_rst_high: assert property (@(posedge clock)
    sys_rst |=> thrHigh == `EHR_RST_THR_HIGH)
    else $error("high threshold reset wrong");
  a_rst_cap: assert property (@(posedge clock)
    sys_rst |=> startupCurrentCap == `EHR_RST_STARTUP)
    else $error("startup cap reset wrong");
  a_rst_counts: assert property (@(posedge clock)
    sys_rst |=> sampleCount == 24'h000000 && energyWrapCount == 16'h0000)
    else $error("counters reset wrong");
  a_rst_answer: assert property (@(posedge clock)
    sys_rst |=> !rdValid && rdData == 64'h0)
    else $error("read answer reset wrong");
  // the pin starts low whatever the mode inputs say
  a_rst_pin: assert property (@(posedge clock)
    sys_rst |=> !gpoOut)
    else $error("gpo reset wrong");

endmodule : energy_and_hysteresis_regs

// ---- verification/ehr_host.sv ----
`timescale 1ns/1ns
// =====
// host model: issues register writes and reads
module ehr_host
  import ehr_pkg::*;
(
  input  wire logic        clock,   // core clock
  input  wire logic        rdValid, // read answer pulse
  input  wire logic [63:0] rdData,  // read answer data
  output ehr_req_t         req      // request to the bank
);
  // idle bus at time zero
  initial req = '{wrEn: 1'b0, rdEn: 1'b0, cmd: 8'h00, wrData: 16'h0000};
  // one-cycle write, lines scrambled once released
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clock) #1;
    req = '{wrEn: 1'b1, rdEn: 1'b0, cmd: c, wrData: d};
    @(posedge clock) #1;
    req = '{wrEn: 1'b0, rdEn: 1'b0, cmd: ~c, wrData: ~d};
  endtask : wr
  // one-cycle read, answer awaited for a bounded time
  task automatic rd(input logic [7:0] c, output logic [63:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clock) #1;
    req = '{wrEn: 1'b0, rdEn: 1'b1, cmd: c, wrData: 16'h0000};
    @(posedge clock) #1;
    req = '{wrEn: 1'b0, rdEn: 1'b0, cmd: ~c, wrData: 16'hffff};
    while (rdValid !== 1'b1 && n < 4)
    begin
      @(posedge clock) #1;
      n++;
    end
    ok = rdValid;
    q = rdData;
  endtask : rd
endmodule : ehr_host

// ---- verification/tb_energy_and_hysteresis_regs.sv ----
`timescale 1ns/1ns
`include "ehr_map.svh"
// =====
// bench for the energy and band registers
module tb_energy_and_hysteresis_regs
  import ehr_pkg::*;
();
  logic        clock = 1'b0; // 125 MHz
  logic        sys_rst;      // sync reset
  ehr_req_t    req;          // from host model
  logic        sampleValid;  // sample pulse
  logic        accumWrap;    // wrap pulse
  logic [23:0] energyAccumIn; // live accumulator
  logic [15:0] comparedValue; // comparator input
  logic        overcurrentPin; // warning input
  logic [1:0]  gpoMode;      // pin mode
  logic        gpoManual;    // manual pin level
  logic [63:0] rdData;       // read data
  logic        rdValid;      // read pulse
  logic        gpoOut;       // pin level
  logic [3:0]  startupCurrentCap; // cap output
  int          bad_count = 0; // mismatches
  int          comparisons = 0; // compares made
  // clock
  always #4 clock = ~clock;
  energy_and_hysteresis_regs dut (.clock(clock), .sys_rst(sys_rst), .req(req),
    .sampleValid(sampleValid), .accumWrap(accumWrap), .energyAccumIn(energyAccumIn),
    .comparedValue(comparedValue), .overcurrentPin(overcurrentPin), .gpoMode(gpoMode),
    .gpoManual(gpoManual), .rdData(rdData), .rdValid(rdValid), .gpoOut(gpoOut),
    .startupCurrentCap(startupCurrentCap));
  ehr_host host (.clock(clock), .rdValid(rdValid), .rdData(rdData), .req(req));
  // =====
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock) #1;
  endtask : cyc
  // read and compare, a missing answer ends the run
  task automatic rdchk(input logic [7:0] c, input logic [63:0] want);
    logic [63:0] q;
    logic        ok;
    host.rd(c, q, ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      tally_and_finish();
    end
    else
      chk(q, want);
  endtask : rdchk
  // =====
  // scenarios
  task automatic t_reset();
    rdchk(`EHR_CMD_THR_LOW, 64'h0);
    rdchk(`EHR_CMD_THR_HIGH, 64'hffff);
    rdchk(`EHR_CMD_STARTUP, 64'hf);
    rdchk(`EHR_CMD_STATUS, 64'h0);
    chk({60'h0, startupCurrentCap}, 64'hf);
  endtask : t_reset
  task automatic t_write();
    host.wr(`EHR_CMD_THR_LOW, 16'h1000);
    host.wr(`EHR_CMD_THR_HIGH, 16'h2000);
    host.wr(`EHR_CMD_STARTUP, 16'hfffa);
    host.wr(`EHR_CMD_STATUS, 16'hffff);
    rdchk(`EHR_CMD_THR_LOW, 64'h1000);
    rdchk(`EHR_CMD_THR_HIGH, 64'h2000);
    rdchk(`EHR_CMD_STARTUP, 64'ha);
    chk({60'h0, startupCurrentCap}, 64'ha);
    rdchk(`EHR_CMD_STATUS, 64'h0);
    rdchk(8'haa, 64'h0);
  endtask : t_write
  task automatic t_band();
    gpoMode = `EHR_GPO_COMPARATOR;
    comparedValue = 16'h3000;
    cyc(2);
    rdchk(`EHR_CMD_STATUS, 64'h6);
    chk({63'h0, gpoOut}, 64'h1);
    comparedValue = 16'h1800;
    cyc(2);
    rdchk(`EHR_CMD_STATUS, 64'h4);
    comparedValue = 16'h0800;
    cyc(2);
    rdchk(`EHR_CMD_STATUS, 64'h1);
    chk({63'h0, gpoOut}, 64'h0);
    comparedValue = 16'h2000;
    cyc(2);
    rdchk(`EHR_CMD_STATUS, 64'h0);
    gpoMode = 2'h1;
    gpoManual = 1'b1;
    cyc(2);
    chk({63'h0, gpoOut}, 64'h1);
  endtask : t_band
  task automatic t_warn();
    overcurrentPin = 1'b1;
    cyc(6);
    rdchk(`EHR_CMD_STATUS, 64'h8);
    overcurrentPin = 1'b0;
    cyc(6);
    rdchk(`EHR_CMD_STATUS, 64'h0);
    // a one-cycle glitch must not reach the warning bit
    overcurrentPin = 1'b1;
    cyc(1);
    overcurrentPin = 1'b0;
    cyc(6);
    rdchk(`EHR_CMD_STATUS, 64'h0);
  endtask : t_warn
  task automatic t_snap();
    sampleValid = 1'b1;
    cyc(5);
    sampleValid = 1'b0;
    accumWrap = 1'b1;
    cyc(2);
    accumWrap = 1'b0;
    energyAccumIn = 24'h123456;
    rdchk(`EHR_CMD_SNAPSHOT, {24'h000005, 16'h0002, 24'h123456});
    host.wr(`EHR_CMD_SNAPSHOT, 16'hffff);
    rdchk(`EHR_CMD_SNAPSHOT, {24'h000005, 16'h0002, 24'h123456});
    // count keeps running: the answer holds the value at the request edge
    sampleValid = 1'b1;
    rdchk(`EHR_CMD_SNAPSHOT, {24'h000006, 16'h0002, 24'h123456});
    sampleValid = 1'b0;
  endtask : t_snap
  // reset again in mid-run, after all registers were changed
  task automatic t_rerst();
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    rdchk(`EHR_CMD_THR_LOW, 64'h0);
    rdchk(`EHR_CMD_THR_HIGH, 64'hffff);
    rdchk(`EHR_CMD_STARTUP, 64'hf);
    chk({60'h0, startupCurrentCap}, 64'hf);
    rdchk(`EHR_CMD_STATUS, 64'h0);
    rdchk(`EHR_CMD_SNAPSHOT, {40'h0, 24'h123456});
  endtask : t_rerst
  // =====
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    sampleValid = 1'b0;
    accumWrap = 1'b0;
    energyAccumIn = 24'h0;
    comparedValue = 16'h1800;
    overcurrentPin = 1'b0;
    gpoMode = 2'h0;
    gpoManual = 1'b0;
    repeat (4) @(posedge clock);
    #1 sys_rst = 1'b0;
    t_reset();
    t_write();
    t_band();
    t_warn();
    t_snap();
    t_rerst();
    tally_and_finish();
  end
endmodule : tb_energy_and_hysteresis_regs
